// file: core/adc_sel_pkg.sv
// Package: register map, field layout, timing and types of the channel select block
package adc_sel_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h70;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h71;
  localparam logic [7:0] ADDR_CTRL_A    = 8'h7A;
  localparam logic [7:0] ADDR_CTRL_B    = 8'h7B;
  localparam logic [7:0] ADDR_INPUT_SEL = 8'h7C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_SUPPLY_OK  = 7;
  localparam int B_CMP_MUX_EN = 6;
  localparam int B_VREF_OK    = 5;
  localparam int B_ARST_REQ   = 4;
  localparam int B_CHAN_MSB   = 3;
  localparam int A_ENABLE     = 7;
  localparam int A_BUSY       = 6;
  localparam int A_AUTO_TRIG  = 5;
  localparam int A_DONE       = 4;
  localparam int S_VREF_HI    = 7;
  localparam int S_LEFT_ADJ   = 5;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_SUPPLY   = 1;
  localparam int IRQ_VREF     = 2;
  localparam int IRQ_ARST     = 3;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         VREF_STARTUP_NS = 20000;
  localparam logic [9:0] VREF_STARTUP_CYC =
    10'((VREF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] ARST_PHASE_CYC  = 3'h4;
  // ----------------------------------------------------------------
  // Selector codes and types
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_BANDGAP = 6'h1E;
  localparam logic [5:0] CODE_GND     = 6'h1F;
  localparam logic [5:0] CODE_TEMP    = 6'h29;
  localparam logic [5:0] CODE_BIAS_P  = 6'h34;
  localparam logic [5:0] CODE_BIAS_N  = 6'h3D;
  typedef enum logic [2:0] {SRC_NONE, SRC_PIN, SRC_BANDGAP, SRC_GND,
                            SRC_TEMP, SRC_BIAS_P, SRC_BIAS_N} src_t;
  typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} gain_t;
  typedef enum logic [1:0] {AR_IDLE, AR_WAIT, AR_PHASE} ar_state_t;
  typedef struct packed {
    src_t       src;
    logic       diff;
    gain_t      gain;
    logic [2:0] pos;
    logic [1:0] neg;
  } route_t;
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic       cmp_mux_en;
    logic       buf_msb;
    logic [2:0] trig_sel;
    logic [1:0] vref_sel;
    logic       left_adj;
    logic [5:0] pend_sel;
    logic [5:0] act_sel;
    route_t     route;
    logic       arst_req;
    ar_state_t  ar_state;
    logic [2:0] ar_cnt;
    logic       arst;
    logic [9:0] vref_cnt;
    logic       vref_ok;
    logic       vref_en;
    logic       supply_ok;
    logic       supply_req;
    logic       sel_flag_q;
    logic       trig;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic       irq;
    logic [7:0] rdata;
  } state_t;
endpackage : adc_sel_pkg

// file: core/adc_chan_select.sv
// Channel select, supply and reference status logic of the A/D converter
// What this block does
// - Low selector writes during a conversion wait until that conversion completes.
// - Writing the low selector bits copies the buffered top bit into use.
// - Writing the top selector bit alone only loads a holding buffer.
// - A top bit change during a conversion waits until it completes.
// - Enable requests analog supply unless another function already requested it.
// - Bit 7 of control B reads 1 once analog supply is up.
// - Enable switches on the chosen reference at once; only the ready flag waits a start-up delay.
// - Bit 5 reads 1 when the internal reference nears its final level.
// - Writing 1 to bit 4 forces an analog reset phase, channel unchanged.
// - The reset request reads one until the reset phase is entered.
// - Bit 6 is a read/write comparator bit with no channel effect.
// - Codes 0-7 select single inputs; 0x1E bandgap; 0x1F ground.
// - Codes 8-15 are differential pairs at 10x or 200x gain.
// - Codes 16-29 are unity gain pairs against input 1 or 2.
// - Code 0x29 selects temperature sensor; 0x34 positive retention bias.
// - Code 0x3D selects negative retention bias; other high codes reserved.
// - Auto trigger takes rising edge of chosen flag; zero never triggers.
`timescale 1ns/1ps
`default_nettype none
module adc_chan_select (
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [7:0]          reg_rdata_o,
  input  wire logic                conv_busy_i,
  input  wire logic                conv_done_i,
  input  wire logic                supply_good_i,
  input  wire logic                other_supply_req_i,
  input  wire logic [7:0]          trig_flags_i,
  output logic      [5:0]          act_sel_o,
  output adc_sel_pkg::route_t      route_o,
  output logic                     conv_enable_o,
  output logic                     left_adj_o,
  output logic                     cmp_mux_en_o,
  output logic                     supply_req_o,
  output logic                     vref_en_o,
  output logic      [1:0]          vref_sel_o,
  output logic                     analog_rst_o,
  output logic                     trigger_o,
  output logic                     irq_o
);
  // ----------------------------------------------------------------
  // Selector decode
  // ----------------------------------------------------------------
  function automatic adc_sel_pkg::route_t decode(input logic [5:0] c);
    adc_sel_pkg::route_t r;
    r = '{src: adc_sel_pkg::SRC_NONE, diff: 1'b0, gain: adc_sel_pkg::GAIN_1X,
          pos: 3'h0, neg: 2'h0};
    unique case (c[5:3])
      3'h0: begin
        r.src = adc_sel_pkg::SRC_PIN;
        r.pos = c[2:0];
      end
      3'h1: begin
        r.src  = adc_sel_pkg::SRC_PIN;
        r.diff = 1'b1;
        r.gain = c[1] ? adc_sel_pkg::GAIN_200X : adc_sel_pkg::GAIN_10X;
        r.pos  = c[2] ? {2'h1, c[0]} : {2'h0, c[0]};
        r.neg  = c[2] ? 2'h2 : 2'h0;
      end
      3'h2: begin
        r.src  = adc_sel_pkg::SRC_PIN;
        r.diff = 1'b1;
        r.pos  = c[2:0];
        r.neg  = 2'h1;
      end
      3'h3: begin
        if (c == adc_sel_pkg::CODE_BANDGAP) begin
          r.src = adc_sel_pkg::SRC_BANDGAP;
        end else if (c == adc_sel_pkg::CODE_GND) begin
          r.src = adc_sel_pkg::SRC_GND;
        end else begin
          r.src  = adc_sel_pkg::SRC_PIN;
          r.diff = 1'b1;
          r.pos  = c[2:0];
          r.neg  = 2'h2;
        end
      end
      default: begin
        // Sensor sits on a 10x differential path, bias codes on a unity gain one; rest connect nothing
        if (c == adc_sel_pkg::CODE_TEMP) begin
          r.src  = adc_sel_pkg::SRC_TEMP;
          r.diff = 1'b1;
          r.gain = adc_sel_pkg::GAIN_10X;
        end else if (c == adc_sel_pkg::CODE_BIAS_P) begin
          r.src  = adc_sel_pkg::SRC_BIAS_P;
          r.diff = 1'b1;
        end else if (c == adc_sel_pkg::CODE_BIAS_N) begin
          r.src  = adc_sel_pkg::SRC_BIAS_N;
          r.diff = 1'b1;
        end
      end
    endcase
    return r;
  endfunction : decode

  // ----------------------------------------------------------------
  // State and decoded strobes
  // ----------------------------------------------------------------
  adc_sel_pkg::state_t st;
  adc_sel_pkg::state_t next_st;
  logic wr_a;
  logic wr_b;
  logic wr_sel;
  logic wr_stat;
  logic wr_mask;
  logic enable;
  logic arst_ready;
  logic sel_flag;
  logic [3:0] events;

  // Register strobes
  assign wr_a    = reg_wr_i && (reg_addr_i == adc_sel_pkg::ADDR_CTRL_A);
  assign wr_b    = reg_wr_i && (reg_addr_i == adc_sel_pkg::ADDR_CTRL_B);
  assign wr_sel  = reg_wr_i && (reg_addr_i == adc_sel_pkg::ADDR_INPUT_SEL);
  assign wr_stat = reg_wr_i && (reg_addr_i == adc_sel_pkg::ADDR_IRQ_STAT);
  assign wr_mask = reg_wr_i && (reg_addr_i == adc_sel_pkg::ADDR_IRQ_MASK);
  assign enable  = st.ctrl_a[adc_sel_pkg::A_ENABLE];
  // Reset phase may only start on a powered, idle converter
  assign arst_ready = enable && st.supply_ok && !conv_busy_i;
  // Selected trigger flag; source zero is forced low so it never edges
  assign sel_flag = (st.trig_sel == 3'h0) ? 1'b0 : trig_flags_i[st.trig_sel];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    events  = 4'h0;
    // Control A: enable, auto trigger, interrupt enable, prescaler
    if (wr_a) begin
      next_st.ctrl_a = {reg_wdata_i[7], 1'b0, reg_wdata_i[5], st.ctrl_a[4],
                        reg_wdata_i[3:0]};
      if (reg_wdata_i[adc_sel_pkg::A_DONE]) begin
        next_st.ctrl_a[adc_sel_pkg::A_DONE] = 1'b0;
      end
    end
    // Done flag: a set in the clearing cycle wins
    if (conv_done_i) begin
      next_st.ctrl_a[adc_sel_pkg::A_DONE] = 1'b1;
    end
    // Control B: status flag positions are not writable
    if (wr_b) begin
      next_st.cmp_mux_en = reg_wdata_i[adc_sel_pkg::B_CMP_MUX_EN];
      next_st.buf_msb    = reg_wdata_i[adc_sel_pkg::B_CHAN_MSB];
      next_st.trig_sel   = reg_wdata_i[2:0];
      if (reg_wdata_i[adc_sel_pkg::B_ARST_REQ]) begin
        next_st.arst_req = 1'b1;
      end
    end
    // Low selector write commits the buffered top bit as well
    if (wr_sel) begin
      next_st.vref_sel = reg_wdata_i[adc_sel_pkg::S_VREF_HI -: 2];
      next_st.left_adj = reg_wdata_i[adc_sel_pkg::S_LEFT_ADJ];
      next_st.pend_sel = {st.buf_msb, reg_wdata_i[4:0]};
    end
    // Pending selection held while a conversion runs
    if (!conv_busy_i || conv_done_i) begin
      next_st.act_sel = next_st.pend_sel;
    end
    next_st.route = decode(next_st.act_sel);
    // Supply request and status
    next_st.supply_req = next_st.ctrl_a[adc_sel_pkg::A_ENABLE] && !other_supply_req_i;
    next_st.supply_ok  = supply_good_i;
    // Reference start-up; only internal references report readiness
    next_st.vref_en = enable && (st.vref_sel != 2'h0);
    if (!st.vref_en || !st.vref_sel[1]) begin
      next_st.vref_cnt = 10'h000;
      next_st.vref_ok  = 1'b0;
    end else if (st.vref_cnt == adc_sel_pkg::VREF_STARTUP_CYC) begin
      next_st.vref_ok = 1'b1;
    end else begin
      next_st.vref_cnt = st.vref_cnt + 10'h001;
    end
    // Analog reset phase; the channel is never touched here
    next_st.arst = 1'b0;
    unique case (st.ar_state)
      adc_sel_pkg::AR_IDLE: begin
        if (st.arst_req) begin
          next_st.ar_state = adc_sel_pkg::AR_WAIT;
        end
      end
      adc_sel_pkg::AR_WAIT: begin
        if (arst_ready) begin
          next_st.arst_req = 1'b0;
          next_st.arst     = 1'b1;
          next_st.ar_cnt   = adc_sel_pkg::ARST_PHASE_CYC - 3'h1;
          next_st.ar_state = adc_sel_pkg::AR_PHASE;
          events[adc_sel_pkg::IRQ_ARST] = 1'b1;
        end
      end
      adc_sel_pkg::AR_PHASE: begin
        if (st.ar_cnt == 3'h0) begin
          next_st.ar_state = adc_sel_pkg::AR_IDLE;
        end else begin
          next_st.arst   = 1'b1;
          next_st.ar_cnt = st.ar_cnt - 3'h1;
        end
      end
    endcase
    // Auto trigger on rising edge of the chosen flag
    next_st.sel_flag_q = sel_flag;
    next_st.trig = sel_flag && !st.sel_flag_q && enable
                   && st.ctrl_a[adc_sel_pkg::A_AUTO_TRIG];
    // Interrupt status: write one clears, a new event wins
    events[adc_sel_pkg::IRQ_DONE]   = conv_done_i;
    events[adc_sel_pkg::IRQ_SUPPLY] = next_st.supply_ok && !st.supply_ok;
    events[adc_sel_pkg::IRQ_VREF]   = next_st.vref_ok && !st.vref_ok;
    if (wr_stat) begin
      next_st.irq_stat = st.irq_stat & ~reg_wdata_i[3:0];
    end
    next_st.irq_stat = next_st.irq_stat | events;
    if (wr_mask) begin
      next_st.irq_mask = reg_wdata_i[3:0];
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    // Read data valid the cycle after the strobe only
    next_st.rdata = adc_sel_pkg::RST_BYTE;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        adc_sel_pkg::ADDR_CTRL_A: begin
          next_st.rdata = st.ctrl_a;
          next_st.rdata[adc_sel_pkg::A_BUSY] = conv_busy_i;
        end
        adc_sel_pkg::ADDR_CTRL_B: begin
          next_st.rdata = {st.supply_ok, st.cmp_mux_en, st.vref_ok, st.arst_req,
                           st.buf_msb, st.trig_sel};
        end
        adc_sel_pkg::ADDR_INPUT_SEL: begin
          next_st.rdata = {st.vref_sel, st.left_adj, st.pend_sel[4:0]};
        end
        adc_sel_pkg::ADDR_IRQ_STAT: begin
          next_st.rdata = {4'h0, st.irq_stat};
        end
        adc_sel_pkg::ADDR_IRQ_MASK: begin
          next_st.rdata = {4'h0, st.irq_mask};
        end
        default: begin
          next_st.rdata = adc_sel_pkg::RST_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.route <= '{src: adc_sel_pkg::SRC_PIN, diff: 1'b0,
                    gain: adc_sel_pkg::GAIN_1X, pos: 3'h0, neg: 2'h0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o   = st.rdata;
  assign act_sel_o     = st.act_sel;
  assign route_o       = st.route;
  assign conv_enable_o = st.ctrl_a[adc_sel_pkg::A_ENABLE];
  assign left_adj_o    = st.left_adj;
  assign cmp_mux_en_o  = st.cmp_mux_en;
  assign supply_req_o  = st.supply_req;
  assign vref_en_o     = st.vref_en;
  assign vref_sel_o    = st.vref_sel;
  assign analog_rst_o  = st.arst;
  assign trigger_o     = st.trig;
  assign irq_o         = st.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_HOLD_BUSY: assert property (
    conv_busy_i && !conv_done_i |=> $stable(st.act_sel))
    else $error("selection changed during conversion");
  AST_MSB_COPY: assert property (
    wr_sel |=> st.pend_sel[5] == $past(st.buf_msb))
    else $error("buffered top bit not copied");
  AST_MSB_BUFFER: assert property (
    wr_b && !wr_sel |=> $stable(st.pend_sel))
    else $error("top bit write changed selection");
  AST_MSB_DEFER: assert property (
    (conv_busy_i && !conv_done_i)[*2] |-> $stable(st.act_sel[5]))
    else $error("top bit changed mid conversion");
  AST_SUPPLY_REQ: assert property (
    wr_a && reg_wdata_i[7] && !other_supply_req_i |=> supply_req_o)
    else $error("supply not requested");
  AST_SUPPLY_READ: assert property (
    reg_rd_i && reg_addr_i == adc_sel_pkg::ADDR_CTRL_B
    |=> reg_rdata_o[7] == $past(st.supply_ok))
    else $error("supply flag misread");
  AST_VREF_DELAY: assert property (
    $rose(st.vref_en && st.vref_sel[1]) |-> !st.vref_ok [*8])
    else $error("reference ready too early");
  AST_VREF_OK: assert property (
    st.vref_ok |-> $past(vref_en_o && vref_sel_o[1]))
    else $error("reference flag without internal reference");
  AST_ARST_ENTER: assert property (
    st.ar_state == adc_sel_pkg::AR_WAIT && arst_ready
    |=> !st.arst_req && analog_rst_o ##4 !analog_rst_o)
    else $error("reset phase not entered");
  AST_CMP_MUX: assert property (
    wr_b && (st.act_sel == st.pend_sel || conv_busy_i && !conv_done_i)
    |=> cmp_mux_en_o == $past(reg_wdata_i[6]) && $stable(act_sel_o))
    else $error("comparator bit misbehaves");
  AST_DECODE: assert property (
    route_o == decode(act_sel_o))
    else $error("route does not match selector");
  AST_FREE_RUN: assert property (
    st.trig_sel == 3'h0 |=> !trigger_o)
    else $error("trigger from free running source");

  COV_DEFER: cover property (wr_sel && conv_busy_i ##1 conv_done_i);
  COV_ARST: cover property ($rose(analog_rst_o));
  COV_TRIG: cover property (trigger_o);
  COV_VREF: cover property ($rose(st.vref_ok));
endmodule : adc_chan_select
`default_nettype wire

// file: verification/adc_channel_select_status_tb.sv
// Self-checking testbench of the channel select, supply and reference status block
`timescale 1ns/1ps
`default_nettype none
module adc_channel_select_status_tb;
  // ----------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------
  logic                 sys_clk_i, nrst_i, reg_wr_i, reg_rd_i;
  logic [7:0]           reg_addr_i, reg_wdata_i, reg_rdata_o, trig_flags_i;
  logic                 conv_busy_i, conv_done_i, supply_good_i, other_supply_req_i;
  logic [5:0]           act_sel_o;
  adc_sel_pkg::route_t  route_o;
  logic                 conv_enable_o, left_adj_o, cmp_mux_en_o, supply_req_o, vref_en_o;
  logic [1:0]           vref_sel_o;
  logic                 analog_rst_o, trigger_o, irq_o;
  int                   bad_count, samples_checked, trig_cnt, rst_len;
  logic [7:0]           d;
  logic [5:0]           c;

  adc_chan_select uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .conv_busy_i(conv_busy_i), .conv_done_i(conv_done_i),
    .supply_good_i(supply_good_i), .other_supply_req_i(other_supply_req_i),
    .trig_flags_i(trig_flags_i), .act_sel_o(act_sel_o), .route_o(route_o),
    .conv_enable_o(conv_enable_o), .left_adj_o(left_adj_o), .cmp_mux_en_o(cmp_mux_en_o),
    .supply_req_o(supply_req_o), .vref_en_o(vref_en_o), .vref_sel_o(vref_sel_o),
    .analog_rst_o(analog_rst_o), .trigger_o(trigger_o), .irq_o(irq_o));

  // Clock at 40 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Counts trigger pulses so bursts can be compared as deltas
  always @(posedge sys_clk_i) begin
    if (trigger_o === 1'b1) trig_cnt++;
    if (analog_rst_o === 1'b1) rst_len++;
  end

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask : rd

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : idle

  // Top bit goes to the holding buffer first, the low write then applies both
  task automatic set_sel(input logic [5:0] s);
    wr(adc_sel_pkg::ADDR_CTRL_B, {4'h0, s[5], 3'h0});
    wr(adc_sel_pkg::ADDR_INPUT_SEL, {3'h0, s[4:0]});
    idle(3);
  endtask : set_sel

  // ----------------------------------------------------------------
  // Expected decode of a selector code
  // ----------------------------------------------------------------
  function automatic adc_sel_pkg::src_t exp_src(input logic [5:0] s);
    if (s < 6'h1E) return adc_sel_pkg::SRC_PIN;
    if (s == adc_sel_pkg::CODE_BANDGAP) return adc_sel_pkg::SRC_BANDGAP;
    if (s == adc_sel_pkg::CODE_GND) return adc_sel_pkg::SRC_GND;
    if (s == adc_sel_pkg::CODE_TEMP) return adc_sel_pkg::SRC_TEMP;
    if (s == adc_sel_pkg::CODE_BIAS_P) return adc_sel_pkg::SRC_BIAS_P;
    if (s == adc_sel_pkg::CODE_BIAS_N) return adc_sel_pkg::SRC_BIAS_N;
    return adc_sel_pkg::SRC_NONE;
  endfunction : exp_src

  // Upper byte masks the fields that are defined, lower byte holds them
  function automatic logic [15:0] exp_rt(input logic [5:0] s);
    if (s < 6'h08) return {8'h9C, 3'b000, s[2:0], 2'b00};
    if (s < 6'h10) return {8'hFF, 1'b1, s[1] ? adc_sel_pkg::GAIN_200X : adc_sel_pkg::GAIN_10X,
                           1'b0, s[2], s[0], s[2], 1'b0};
    if (s < 6'h18) return {8'hFF, 1'b1, adc_sel_pkg::GAIN_1X, s[2:0], 2'd1};
    if (s < 6'h1E) return {8'hFF, 1'b1, adc_sel_pkg::GAIN_1X, s[2:0], 2'd2};
    if (s == adc_sel_pkg::CODE_TEMP) return {8'hE0, 1'b1, adc_sel_pkg::GAIN_10X, 5'h00};
    if (s == adc_sel_pkg::CODE_BIAS_P || s == adc_sel_pkg::CODE_BIAS_N)
      return {8'hE0, 1'b1, adc_sel_pkg::GAIN_1X, 5'h00};
    return 16'h0000;
  endfunction : exp_rt

  task automatic chk_sel(input logic [5:0] s);
    logic [15:0] e;
    e = exp_rt(s);
    chk("act_sel", {10'h000, s}, {10'h000, act_sel_o});
    chk("route_src", {13'h0000, exp_src(s)}, {13'h0000, route_o.src});
    chk("route_fields", {8'h00, e[7:0]},
        {8'h00, e[15:8] & {route_o.diff, route_o.gain, route_o.pos, route_o.neg}});
  endtask : chk_sel

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run of about 1300 cycles
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    bad_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h00; reg_wdata_i = 8'h00;
    conv_busy_i = 1'b0; conv_done_i = 1'b0; supply_good_i = 1'b0; other_supply_req_i = 1'b0;
    trig_flags_i = 8'h00; bad_count = 0; samples_checked = 0; trig_cnt = 0; rst_len = 0;
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    void'($urandom(32'h882b_8195));
    // Reset values, unmapped place, read-only flags ignore writes
    rd(adc_sel_pkg::ADDR_CTRL_B, d); chk("ctrl_b_rst", 16'h0000, {8'h00, d});
    rd(adc_sel_pkg::ADDR_CTRL_A, d); chk("ctrl_a_rst", 16'h0000, {8'h00, d});
    rd(adc_sel_pkg::ADDR_INPUT_SEL, d); chk("in_sel_rst", 16'h0000, {8'h00, d});
    rd(8'h55, d); chk("unmapped", 16'h0000, {8'h00, d});
    wr(adc_sel_pkg::ADDR_CTRL_B, 8'hA0);
    rd(adc_sel_pkg::ADDR_CTRL_B, d); chk("ro_flags", 16'h0000, {8'h00, d});
    $display("test reset done");
    // Corner codes then random codes
    for (int i = 0; i < 50; i++) begin
      c = (i < 18) ? 6'({6'h00, 6'h07, 6'h08, 6'h0B, 6'h0C, 6'h0F, 6'h10, 6'h17, 6'h18,
                         6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h28, 6'h29, 6'h34, 6'h3D,
                         6'h3F} >> (6 * (17 - i))) : 6'($urandom);
      set_sel(c);
      chk_sel(c);
    end
    $display("test decode done");
    // Top bit alone only loads the buffer
    set_sel(6'h09);
    wr(adc_sel_pkg::ADDR_CTRL_B, 8'h08);
    idle(3);
    chk_sel(6'h09);
    wr(adc_sel_pkg::ADDR_INPUT_SEL, 8'h09);
    idle(3);
    chk_sel(6'h29);
    // Changes during a conversion wait for its completion
    conv_busy_i <= 1'b1;
    set_sel(6'h1E);
    idle(4);
    chk_sel(6'h29);
    @(posedge sys_clk_i);
    conv_done_i <= 1'b1;
    @(posedge sys_clk_i);
    conv_done_i <= 1'b0;
    idle(3);
    chk_sel(6'h1E);
    conv_busy_i <= 1'b0;
    $display("test buffering done");
    // Comparator bit stays out of the selection
    wr(adc_sel_pkg::ADDR_CTRL_B, 8'h40);
    idle(2);
    chk("cmp_mux", 16'h0001, {15'h0000, cmp_mux_en_o});
    rd(adc_sel_pkg::ADDR_CTRL_B, d); chk("ctrl_b_cmp", 16'h0040, {8'h00, d});
    chk_sel(6'h1E);
    // Supply request, with and without another requester
    other_supply_req_i <= 1'b1;
    wr(adc_sel_pkg::ADDR_CTRL_A, 8'h80);
    idle(3);
    chk("supply_req_other", 16'h0000, {15'h0000, supply_req_o});
    other_supply_req_i <= 1'b0;
    idle(3);
    chk("supply_req", 16'h0001, {15'h0000, supply_req_o});
    chk("conv_enable", 16'h0001, {15'h0000, conv_enable_o});
    supply_good_i <= 1'b1;
    idle(3);
    rd(adc_sel_pkg::ADDR_CTRL_B, d); chk("supply_ok", 16'h00C0, {8'h00, d});
    $display("test supply done");
    // Analog reset held off by a running conversion, irq on entry
    wr(adc_sel_pkg::ADDR_IRQ_STAT, 8'h0F);
    wr(adc_sel_pkg::ADDR_IRQ_MASK, 8'h08);
    idle(2);
    chk("irq_idle", 16'h0000, {15'h0000, irq_o});
    conv_busy_i <= 1'b1;
    wr(adc_sel_pkg::ADDR_CTRL_B, 8'h10);
    idle(8);
    rd(adc_sel_pkg::ADDR_CTRL_B, d); chk("arst_pending", 16'h0090, {8'h00, d});
    chk("arst_held", 16'h0000, {15'h0000, analog_rst_o});
    rst_len = 0;
    conv_busy_i <= 1'b0;
    idle(12);
    chk("arst_len", 16'(adc_sel_pkg::ARST_PHASE_CYC), 16'(rst_len));
    rd(adc_sel_pkg::ADDR_CTRL_B, d); chk("arst_clear", 16'h0080, {8'h00, d});
    chk_sel(6'h1E);
    chk("irq_set", 16'h0001, {15'h0000, irq_o});
    wr(adc_sel_pkg::ADDR_IRQ_MASK, 8'h00);
    idle(2);
    chk("irq_masked", 16'h0000, {15'h0000, irq_o});
    wr(adc_sel_pkg::ADDR_IRQ_MASK, 8'h08);
    wr(adc_sel_pkg::ADDR_IRQ_STAT, 8'h08);
    idle(2);
    chk("irq_cleared", 16'h0000, {15'h0000, irq_o});
    rd(adc_sel_pkg::ADDR_IRQ_STAT, d); chk("irq_stat", 16'h0000, {8'h00, d & 8'h08});
    $display("test analog reset done");
    // Internal reference start-up
    wr(adc_sel_pkg::ADDR_INPUT_SEL, 8'hFE);
    idle(3);
    chk("vref_en", 16'h0001, {15'h0000, vref_en_o});
    chk("vref_sel", 16'h0003, {14'h0000, vref_sel_o});
    chk("left_adj", 16'h0001, {15'h0000, left_adj_o});
    chk_sel(6'h1E);
    idle(int'(adc_sel_pkg::VREF_STARTUP_CYC) - 40);
    rd(adc_sel_pkg::ADDR_CTRL_B, d); chk("vref_early", 16'h0000, {8'h00, d & 8'h20});
    idle(60);
    rd(adc_sel_pkg::ADDR_CTRL_B, d); chk("vref_ok", 16'h0020, {8'h00, d & 8'h20});
    $display("test reference done");
    // Auto trigger on a rising flag, on a switch to a set flag, never in free running
    wr(adc_sel_pkg::ADDR_CTRL_A, 8'hA0);
    wr(adc_sel_pkg::ADDR_CTRL_B, 8'h03);
    idle(2);
    trig_cnt = 0;
    trig_flags_i <= 8'h20;
    idle(4);
    trig_flags_i <= 8'h28;
    idle(4);
    chk("trig_rise", 16'h0001, 16'(trig_cnt));
    // Old source cleared first, so the switch meets a set flag from a cleared one
    trig_flags_i <= 8'h20;
    wr(adc_sel_pkg::ADDR_CTRL_B, 8'h05);
    idle(4);
    chk("trig_switch", 16'h0002, 16'(trig_cnt));
    trig_flags_i <= 8'h01;
    wr(adc_sel_pkg::ADDR_CTRL_B, 8'h00);
    idle(4);
    trig_flags_i <= 8'h00;
    idle(2);
    trig_flags_i <= 8'h01;
    idle(4);
    chk("trig_free", 16'h0002, 16'(trig_cnt));
    $display("test trigger done");
    end_sim();
  end
endmodule : adc_channel_select_status_tb
`default_nettype wire
